// file: design/flash_prot_map.svh
/*
  Constants for the flash protect and unlock controller: register offsets,
  key codes, geometry and timing. Assumes inclusion by bare name.
*/
// Functional notes
// (R1) With the write-permit option bit at 0, user program, page erase and mass erase are all refused; the code does not gate debug mass erase.
// (R2) With the write-permit option bit at 1, program and erase are allowed subject to the other locks.
// (R3) Every reset leaves the controller locked with no active page.
// (R4) Software unlocks by writing page select, then 73h and 8ch to control in two consecutive writes.
// (R5) A second page-select write after the keys activates the page if it matches, else relocks.
// (R6) With a page active, control write 95h erases that page only if its sector is unprotected.
// (R7) With a page active, any other control value relocks without an operation.
// (R8) Mass erase is never started by a control write; only the debug port may start it.
// (R9) With a page active, a byte write inside that page programs it and the page stays active.
// (R10) Any control write after byte programming began deactivates the page and relocks.
// (R11) Flash has at most 8 sectors of one eighth each, but never smaller than a page; the code uses 8 sectors of 256 bytes, half a 512-byte page.
// (R12) A protected sector cannot be programmed or erased and user code cannot unprotect it; the code does not block debug mass erase of protected sectors.
// (R13) Every reset clears sector protection.
// (R14) Sector protect shares its address with page select, selected by a prior control write.
// (R15) Software must load the 16-bit flash frequency value in kHz before program or erase.
// (R16) Writing 1 to a protect bit sets it; writing 0 has no effect.
// (R17) A dedicated control code selects the protect view; any other control write selects page select.
`ifndef FLASH_PROT_MAP_SVH
`define FLASH_PROT_MAP_SVH

`define OFS_CTRL 12'h000
`define OFS_PAGE_PROT 12'h004
`define OFS_FREQ_HI 12'h008
`define OFS_FREQ_LO 12'h00c
`define OFS_STATUS 12'h010
`define OFS_PROG 12'h014

`define KEY_FIRST 8'h73
`define KEY_SECOND 8'h8c
`define CODE_PAGE_ERASE 8'h95
`define CODE_PROT_VIEW 8'h5e

`define FLASH_BYTES 32'd2048
`define PAGE_BYTES 32'd512
`define ADDR_W 11
`define PAGE_W 2
`define SECTOR_COUNT 8

// time per operation in microseconds, scaled by the loaded kHz value
`define PROG_TIME_US 32'd40
`define ERASE_TIME_US 32'd10000
`define STATUS_BUSY_BIT 0
`define STATUS_ACTIVE_BIT 1
`define STATUS_PROT_VIEW_BIT 2
`define STATUS_REFUSED_BIT 3

`endif

// file: design/flash_prot_pkg.sv
/*
  Types of the flash protect and unlock controller.
  Assumes flash_prot_map.svh for the figures.
*/
`include "flash_prot_map.svh"
package flash_prot_pkg;
  typedef enum logic [2:0] {
    ST_LOCKED = 3'b000,
    ST_KEY1 = 3'b001,
    ST_KEY2 = 3'b010,
    ST_ACTIVE = 3'b011,
    ST_PROGRAMMED = 3'b100
  } lock_state_t;

  typedef struct packed {
    logic go;
    logic erase;
    logic mass;
    logic [`ADDR_W-1:0] addr;
    logic [7:0] data;
  } flash_cmd_t;

  typedef struct packed {
    logic [7:0] prdata;
    logic [`PAGE_W-1:0] page_first;
    lock_state_t state;
    logic prot_view;
    logic [`SECTOR_COUNT-1:0] sector_prot;
    logic [7:0] freq_hi_hold;
    logic [15:0] freq_khz;
    logic refused;
    flash_cmd_t cmd;
  } ctrl_state_t;
endpackage

// file: design/flash_op_timer.sv
/*
  Busy timer for one flash operation: counts the loaded kHz value
  times the operation length in microseconds, divided by 1000.
  Assumes a start pulse only while not busy.
*/
`timescale 1ns/1ns
`default_nettype none
module flash_op_timer
  import flash_prot_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic start,
  input wire logic [31:0] time_us,
  input wire logic [15:0] freq_khz,
  output logic busy
);
  logic [31:0] count_r;
  logic [31:0] count_nxt;
  logic [47:0] cycles;

  // kHz times microseconds gives thousandths of a cycle count
  always_comb begin
    cycles = 48'(freq_khz) * 48'(time_us) / 48'd1000;
    count_nxt = count_r;
    if (start) begin
      count_nxt = (cycles[31:0] == 32'd0) ? 32'd1 : cycles[31:0];
    end else if (count_r != 32'd0) begin
      count_nxt = count_r - 32'd1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      count_r <= 32'd0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign busy = (count_r != 32'd0);
endmodule
`default_nettype wire

// file: design/flash_protect_unlock_ctrl.sv
/*
  Flash protect and unlock controller with an APB register slave.
  Assumes a flash array outside that acts on the one-cycle command strobe,
  a debug port that may request mass erase, and an option bit level.
*/
// The APB slave port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_map.svh"
module flash_protect_unlock_ctrl
  import flash_prot_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // option bit and debug port
  input wire logic WRITE_PERMIT_OPTION,
  input wire logic DBG_MASS_ERASE_REQ,
  // flash array command
  output logic FLASH_GO,
  output logic FLASH_ERASE,
  output logic FLASH_MASS,
  output logic [`ADDR_W-1:0] FLASH_ADDR,
  output logic [7:0] FLASH_DATA,
  output logic FLASH_BUSY
);
  ctrl_state_t st_r;
  ctrl_state_t st_nxt;
  logic busy;
  logic timer_start;
  logic [31:0] timer_us;
  logic wr;
  logic rd;
  logic mapped;
  logic [7:0] wbyte;
  logic [`ADDR_W-1:0] prog_addr;
  logic [2:0] sector_of_page;
  logic [2:0] sector_of_addr;
  logic page_ok;

  flash_op_timer u_timer (
    .clk(CORE_CLK),
    .rst(RESET),
    .start(timer_start),
    .time_us(timer_us),
    .freq_khz(st_r.freq_khz),
    .busy(busy)
  );

  // zero wait-state slave: every access completes in its first access cycle
  // read data is captured in the setup cycle so it already stands when the access edge samples it
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PENABLE && !PWRITE;
  assign wbyte = PWDATA[7:0];
  assign PREADY = 1'b1;
  assign mapped = (PADDR == `OFS_CTRL) || (PADDR == `OFS_PAGE_PROT) || (PADDR == `OFS_FREQ_HI)
    || (PADDR == `OFS_FREQ_LO) || (PADDR == `OFS_STATUS) || (PADDR == `OFS_PROG);
  assign PSLVERR = PSEL && PENABLE && !mapped;
  assign prog_addr = PWDATA[8 +: `ADDR_W];

  // sector is the top three address bits: pages of 512 bytes span two sectors each
  assign sector_of_page = {st_r.page_first, 1'b0}; // R11
  assign sector_of_addr = prog_addr[`ADDR_W-1 -: 3]; // R11
  assign page_ok = (prog_addr[`ADDR_W-1 -: `PAGE_W] == st_r.page_first);

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd.go = 1'b0;
    timer_start = 1'b0;
    timer_us = `PROG_TIME_US;
    if (rd) begin
      case (PADDR)
        `OFS_PAGE_PROT: st_nxt.prdata = st_r.prot_view ? st_r.sector_prot
          : {{(8-`PAGE_W){1'b0}}, st_r.page_first}; // R14
        `OFS_FREQ_HI: st_nxt.prdata = st_r.freq_khz[15:8];
        `OFS_FREQ_LO: st_nxt.prdata = st_r.freq_khz[7:0];
        `OFS_STATUS: begin
          st_nxt.prdata = 8'h00;
          st_nxt.prdata[`STATUS_BUSY_BIT] = busy;
          st_nxt.prdata[`STATUS_ACTIVE_BIT] = (st_r.state == ST_ACTIVE) || (st_r.state == ST_PROGRAMMED);
          st_nxt.prdata[`STATUS_PROT_VIEW_BIT] = st_r.prot_view;
          st_nxt.prdata[`STATUS_REFUSED_BIT] = st_r.refused;
        end
        default: st_nxt.prdata = 8'h00;
      endcase
    end
    // mass erase only from the debug port, not gated by the option bit
    if (DBG_MASS_ERASE_REQ && !busy) begin // R8 R1
      st_nxt.cmd = '{go: 1'b1, erase: 1'b1, mass: 1'b1, addr: '0, data: 8'h00};
      timer_start = 1'b1;
      timer_us = `ERASE_TIME_US;
    end else if (wr) begin
      case (PADDR)
        `OFS_CTRL: begin
          st_nxt.prot_view = (wbyte == `CODE_PROT_VIEW); // R17
          case (st_r.state)
            ST_LOCKED: st_nxt.state = (wbyte == `KEY_FIRST) ? ST_KEY1 : ST_LOCKED; // R4
            ST_KEY1: st_nxt.state = (wbyte == `KEY_SECOND) ? ST_KEY2 : ST_LOCKED; // R4
            ST_ACTIVE: begin
              st_nxt.state = ST_LOCKED; // R7
              if (wbyte == `CODE_PAGE_ERASE && !busy) begin
                if (WRITE_PERMIT_OPTION && !st_r.sector_prot[sector_of_page]
                    && !st_r.sector_prot[sector_of_page + 3'd1]) begin // R6 R2 R12
                  st_nxt.cmd = '{go: 1'b1, erase: 1'b1, mass: 1'b0,
                    addr: {st_r.page_first, {(`ADDR_W-`PAGE_W){1'b0}}}, data: 8'h00};
                  timer_start = 1'b1;
                  timer_us = `ERASE_TIME_US;
                end else begin
                  st_nxt.refused = 1'b1; // R1
                end
              end
            end
            ST_PROGRAMMED: st_nxt.state = ST_LOCKED; // R10
            default: st_nxt.state = ST_LOCKED;
          endcase
        end
        `OFS_PAGE_PROT: begin
          if (st_r.prot_view) begin
            st_nxt.sector_prot = st_r.sector_prot | wbyte; // R16 R12
          end else begin
            case (st_r.state)
              ST_KEY2: st_nxt.state = (wbyte[`PAGE_W-1:0] == st_r.page_first) ? ST_ACTIVE : ST_LOCKED; // R5
              default: begin
                st_nxt.page_first = wbyte[`PAGE_W-1:0]; // R4
                // a page rewrite during the key pair breaks the sequence
                if (st_r.state == ST_KEY1) begin
                  st_nxt.state = ST_LOCKED;
                end else if (st_r.state != ST_LOCKED) begin
                  st_nxt.state = ST_LOCKED;
                end
              end
            endcase
          end
        end
        `OFS_FREQ_HI: st_nxt.freq_hi_hold = wbyte; // R15
        `OFS_FREQ_LO: st_nxt.freq_khz = {st_r.freq_hi_hold, wbyte}; // R15
        `OFS_PROG: begin
          // data byte in bits 7:0, byte address above it
          if ((st_r.state == ST_ACTIVE || st_r.state == ST_PROGRAMMED) && page_ok && !busy) begin
            if (WRITE_PERMIT_OPTION && !st_r.sector_prot[sector_of_addr]) begin // R9 R2 R12
              st_nxt.cmd = '{go: 1'b1, erase: 1'b0, mass: 1'b0, addr: prog_addr, data: wbyte};
              st_nxt.state = ST_PROGRAMMED; // R9
              timer_start = 1'b1;
            end else begin
              st_nxt.refused = 1'b1; // R1
            end
          end else begin
            st_nxt.refused = 1'b1; // R3
          end
        end
        default: st_nxt.refused = st_r.refused;
      endcase
    end
    if (wr && PADDR == `OFS_STATUS && wbyte[`STATUS_REFUSED_BIT]) begin
      st_nxt.refused = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (RESET) begin
      st_r <= '0; // R3 R13
      st_r.state <= ST_LOCKED; // R3
    end else begin
      st_r <= st_nxt;
    end
  end

  assign PRDATA = {24'h000000, st_r.prdata};
  assign FLASH_GO = st_r.cmd.go;
  assign FLASH_ERASE = st_r.cmd.erase;
  assign FLASH_MASS = st_r.cmd.mass;
  assign FLASH_ADDR = st_r.cmd.addr;
  assign FLASH_DATA = st_r.cmd.data;
  assign FLASH_BUSY = busy;
endmodule
`default_nettype wire

// file: dv/flash_unlock_checker.sv
/* Port checker of the flash unlock controller.
   Assumes binding to the top module by the statement below. */
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_map.svh"
module flash_unlock_checker
  import flash_prot_pkg::*;
(
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RESET,
  // apb
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  // option and debug
  input wire logic WRITE_PERMIT_OPTION,
  input wire logic DBG_MASS_ERASE_REQ,
  // flash command
  input wire logic FLASH_GO,
  input wire logic FLASH_ERASE,
  input wire logic FLASH_MASS,
  input wire logic [`ADDR_W-1:0] FLASH_ADDR,
  input wire logic [7:0] FLASH_DATA,
  input wire logic FLASH_BUSY
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  logic wr_acc;
  logic erase_wr;
  logic prog_wr;
  assign wr_acc = PSEL && PENABLE && PWRITE;
  assign erase_wr = wr_acc && PADDR == `OFS_CTRL && PWDATA[7:0] == `CODE_PAGE_ERASE;
  assign prog_wr = wr_acc && PADDR == `OFS_PROG;
  sequence locked_prog;
    prog_wr && !WRITE_PERMIT_OPTION;
  endsequence
  sequence dbg_start;
    $rose(DBG_MASS_ERASE_REQ) && !FLASH_BUSY && !FLASH_GO;
  endsequence
  go_one_cycle_a: assert property (FLASH_GO |=> !FLASH_GO) else $error("go longer than one cycle");
  quiet_reset_a: assert property ($past(RESET) |-> !FLASH_GO) else $error("command right after reset");
  permit_gate_a: assert property (FLASH_GO && !FLASH_MASS |-> $past(WRITE_PERMIT_OPTION))
    else $error("user command without permit");
  user_mass_a: assert property (FLASH_GO && FLASH_MASS |-> $past(DBG_MASS_ERASE_REQ))
    else $error("mass erase without debug");
  locked_prog_a: assert property (locked_prog |=> !FLASH_GO) else $error("program while not permitted");
  erase_code_a: assert property (FLASH_GO && FLASH_ERASE && !FLASH_MASS |-> $past(erase_wr))
    else $error("erase without erase code");
  prog_byte_a: assert property (FLASH_GO && !FLASH_ERASE && !FLASH_MASS |-> $past(prog_wr) &&
    ($past(PWDATA) & 32'h0007ffff) == {13'h0, FLASH_ADDR, FLASH_DATA}) else $error("program byte wrong");
  dbg_mass_a: assert property (dbg_start |=> FLASH_GO && FLASH_MASS) else $error("debug mass erase lost");
endmodule
bind flash_protect_unlock_ctrl flash_unlock_checker chk (.CORE_CLK(CORE_CLK), .RESET(RESET), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .WRITE_PERMIT_OPTION(WRITE_PERMIT_OPTION),
  .DBG_MASS_ERASE_REQ(DBG_MASS_ERASE_REQ), .FLASH_GO(FLASH_GO), .FLASH_ERASE(FLASH_ERASE),
  .FLASH_MASS(FLASH_MASS), .FLASH_ADDR(FLASH_ADDR), .FLASH_DATA(FLASH_DATA), .FLASH_BUSY(FLASH_BUSY));
`default_nettype wire

// file: dv/flash_protect_unlock_ctrl_test.sv
/* Testbench of the flash unlock controller: APB tasks and scenarios.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`default_nettype none
`include "flash_prot_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin num_errors++; $display("mismatch %s exp %h got %h", n, e, g); end end
module flash_protect_unlock_ctrl_test import flash_prot_pkg::*;;
  logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, opt = 0, dbg = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata;
  logic pready, pslverr, go, er, ms, busy;
  logic [`ADDR_W-1:0] fa;
  logic [7:0] fd;
  int num_errors = 0, comparisons = 0, gos = 0;
  always #2 clk = ~clk;
  always @(posedge clk) if (go) gos++;
  flash_protect_unlock_ctrl DUT (.CORE_CLK(clk), .RESET(rst), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .WRITE_PERMIT_OPTION(opt), .DBG_MASS_ERASE_REQ(dbg), .FLASH_GO(go), .FLASH_ERASE(er),
    .FLASH_MASS(ms), .FLASH_ADDR(fa), .FLASH_DATA(fd), .FLASH_BUSY(busy));
  // bus stays selected after a write so that back-to-back writes need no idle cycle
  task automatic acc(input logic [11:0] a, input logic w, input logic [31:0] d);
    psel <= 1;
    pen <= 0;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1;
    @(posedge clk);
    while (!pready) @(posedge clk);
  endtask
  task automatic idle(input int n);
    psel <= 0;
    pen <= 0;
    repeat (n) @(posedge clk);
  endtask
  // read data is taken at the same edge that samples pready high
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    acc(a, 0, 0);
    `CHK("pslverr", a > 12'h014, pslverr)
    if (a <= 12'h014) `CHK("prdata", e, prdata & m)
    idle(1);
  endtask
  task automatic unlock(input logic [31:0] p1, input logic [31:0] p2);
    acc(`OFS_PAGE_PROT, 1, p1);
    acc(`OFS_CTRL, 1, `KEY_FIRST);
    acc(`OFS_CTRL, 1, `KEY_SECOND);
    acc(`OFS_PAGE_PROT, 1, p2);
  endtask
  task automatic reset_dut;
    rst <= 1;
    repeat (6) @(posedge clk);
    rst <= 0;
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end
  initial begin
    reset_dut();
    rd(`OFS_STATUS, 0, 32'hf);
    rd(12'h018, 0, 0);
    acc(`OFS_FREQ_HI, 1, 0);
    acc(`OFS_FREQ_LO, 1, 25);
    rd(`OFS_FREQ_LO, 25, 32'hff);
    rd(`OFS_FREQ_HI, 0, 32'hff);
    unlock(1, 1);
    acc(`OFS_PROG, 1, 32'h205a5);
    rd(`OFS_STATUS, 8, 8);
    `CHK("go count", 0, gos)
    acc(`OFS_STATUS, 1, 8);
    opt <= 1;
    unlock(1, 1);
    rd(`OFS_STATUS, 2, 32'hf);
    acc(`OFS_PROG, 1, 32'h205a5);
    idle(4);
    acc(`OFS_PROG, 1, 32'h3ff3c);
    idle(4);
    `CHK("go count", 2, gos)
    `CHK("prog addr", 11'h3ff, fa)
    `CHK("prog data", 8'h3c, fd)
    rd(`OFS_STATUS, 2, 2);
    acc(`OFS_CTRL, 1, 0);
    rd(`OFS_STATUS, 0, 2);
    unlock(1, 2);
    rd(`OFS_STATUS, 0, 2);
    unlock(2, 2);
    acc(`OFS_CTRL, 1, 32'h11);
    acc(`OFS_PROG, 1, 32'h40011);
    rd(`OFS_STATUS, 0, 2);
    `CHK("go count", 2, gos)
    acc(`OFS_CTRL, 1, `CODE_PROT_VIEW);
    rd(`OFS_PAGE_PROT, 0, 32'hff);
    rd(`OFS_STATUS, 4, 4);
    acc(`OFS_PAGE_PROT, 1, 32'h10);
    acc(`OFS_PAGE_PROT, 1, 0);
    rd(`OFS_PAGE_PROT, 32'h10, 32'hff);
    acc(`OFS_CTRL, 1, 0);
    rd(`OFS_STATUS, 0, 4);
    acc(`OFS_STATUS, 1, 8);
    rd(`OFS_STATUS, 0, 8);
    unlock(2, 2);
    acc(`OFS_PROG, 1, 32'h40011);
    rd(`OFS_STATUS, 8, 8);
    acc(`OFS_CTRL, 1, `CODE_PAGE_ERASE);
    idle(4);
    `CHK("go count", 2, gos)
    unlock(3, 3);
    acc(`OFS_CTRL, 1, `CODE_PAGE_ERASE);
    idle(2);
    `CHK("go count", 3, gos)
    `CHK("erase", 1, er)
    `CHK("erase addr", 11'h600, fa)
    while (busy) @(posedge clk);
    dbg <= 1;
    @(posedge clk);
    dbg <= 0;
    repeat (2) @(posedge clk);
    `CHK("go count", 4, gos)
    `CHK("mass", 1, ms)
    while (busy) @(posedge clk);
    reset_dut();
    acc(`OFS_CTRL, 1, `CODE_PROT_VIEW);
    rd(`OFS_PAGE_PROT, 0, 32'hff);
    results();
  end
endmodule
`default_nettype wire
